// ===== shared/timing_pins_pkg.sv
// Purpose: shared constants for the timing terminal pin block
// Assumes: one system clock, no software-reachable registers
// Notes: pin indices follow the terminal order of the timing pins
package timing_pins_pkg;
  localparam int NUM_PINS = 10;
  localparam int NUM_TIMING_SIGNALS = 13;
  localparam int SEL_W = 4;
  // pin index of each fixed output function
  localparam logic [SEL_W-1:0] PIN_ACQ_TRIG_FIRST = 4'h0;
  localparam logic [SEL_W-1:0] PIN_ACQ_TRIG_SECOND = 4'h1;
  localparam logic [SEL_W-1:0] PIN_CONVERT = 4'h2;
  localparam logic [SEL_W-1:0] PIN_COUNTER_B_SOURCE = 4'h3;
  localparam logic [SEL_W-1:0] PIN_COUNTER_B_GATE = 4'h4;
  localparam logic [SEL_W-1:0] PIN_UPDATE = 4'h5;
  localparam logic [SEL_W-1:0] PIN_WAVEFORM_START = 4'h6;
  localparam logic [SEL_W-1:0] PIN_SCAN_START = 4'h7;
  localparam logic [SEL_W-1:0] PIN_COUNTER_A_SOURCE = 4'h8;
  localparam logic [SEL_W-1:0] PIN_COUNTER_A_GATE = 4'h9;
  // source selector code: below NUM_PINS picks a pin, this picks internal
  localparam logic [SEL_W-1:0] SEL_INTERNAL = 4'hF;
  // reset values
  localparam logic [NUM_PINS-1:0] PIN_OE_RESET = 10'h000;
  localparam logic STROBE_RESET = 1'b1; // strobe is active low, idles high
  // acquisition trigger phases
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_PRE, ACQ_POST} acq_phase_t;
endpackage : timing_pins_pkg

// ===== design/pin_sync.sv
// Purpose: two-stage synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 10
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;
  sync_state_t state_ff;
  sync_state_t nxt_state;

  // shift the pin level through both stages
  always_comb begin
    nxt_state.meta = async_in;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;
endmodule : pin_sync
`default_nettype wire

// ===== design/timing_signal_terminal_pins.sv
// Purpose: programmable timing pins, fixed timing outputs and input routing
// Assumes: timing engines sit elsewhere on the same clock
// Notes: configuration arrives as plain ports, no register file here
// Function
// - software toggles a dedicated strobe output
// - input pin acts as routable timing source
// - posttrigger start rises first acquisition trigger
// - pretrigger start rises first acquisition trigger
// - post phase of a pretrigger run rises second trigger only
// - conversion pin falls on each conversion
// - counter b source pin mirrors selected source
// - counter b gate pin mirrors selected gate
// - counter b output pin carries counter output
// - update pin falls on primary update
// - waveform trigger rises at generation start
// - scan start pulses once per scan
// - counter a source pin mirrors selected source
// - counter a gate pin mirrors selected gate
// - counter a output pin carries counter output
// - frequency pin carries generator output
// - any pin feeds any signal, shared
// - each pin driver enabled individually
// - thirteen timing signals, pin or internal
`timescale 1ns/10ps
`default_nettype none
module timing_signal_terminal_pins
  import timing_pins_pkg::*;
#(
  parameter int NPINS = NUM_PINS,
  parameter int NSIG = NUM_TIMING_SIGNALS
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // software controls
  input wire logic strobe_toggle_in,
  input wire logic [NPINS-1:0] pin_oe_cfg_in,
  input wire logic [NSIG*SEL_W-1:0] source_sel_in,
  input wire logic [NSIG-1:0] internal_source_in,
  // acquisition and output engine events, same clock
  input wire logic acq_start_in,
  input wire logic acq_pretrigger_in,
  input wire logic acq_post_start_in,
  input wire logic acq_done_in,
  input wire logic convert_event_in,
  input wire logic update_event_in,
  input wire logic waveform_start_in,
  input wire logic waveform_done_in,
  input wire logic scan_start_in,
  // counter and generator levels, same clock
  input wire logic counter_a_source_in,
  input wire logic counter_a_gate_in,
  input wire logic counter_a_output_in,
  input wire logic counter_b_source_in,
  input wire logic counter_b_gate_in,
  input wire logic counter_b_output_in,
  input wire logic freq_generator_in,
  // programmable pins, three signals each
  input wire logic [NPINS-1:0] programmable_timing_pin_in,
  output logic [NPINS-1:0] programmable_timing_pin_out,
  output logic [NPINS-1:0] programmable_timing_pin_oe_out,
  // dedicated outputs
  output logic software_strobe_out,
  output logic counter_a_output_out,
  output logic counter_b_output_out,
  output logic freq_generator_output_out,
  // routed timing signals toward the engines
  output logic [NSIG-1:0] timing_signal_out
);
  typedef struct packed {
    logic [NPINS-1:0] pin_drv;
    logic [NPINS-1:0] pin_oe;
    logic strobe;
    logic ctr_a_out;
    logic ctr_b_out;
    logic freq_generator_output;
    logic [NSIG-1:0] timing;
    acq_phase_t acq_phase;
    logic wave_active;
  } pins_state_t;

  pins_state_t state_ff;
  pins_state_t nxt_state;
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] fixed_level;
  logic [NSIG-1:0] routed;

  // pin levels cross into the clock domain before routing
  pin_sync #(.WIDTH(NPINS)) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in(programmable_timing_pin_in),
    .sync_out(pin_sync)
  );

  // per-signal source mux
  // every signal owns its own selector so pins can be shared freely
  genvar gi;
  generate
    for (gi = 0; gi < NSIG; gi++) begin : g_route
      logic [SEL_W-1:0] sel;
      assign sel = source_sel_in[gi*SEL_W +: SEL_W];
      // input pin as source
      // out-of-range codes fall back to the internal source
      assign routed[gi] = (sel < SEL_W'(NPINS)) ? pin_sync[sel] : internal_source_in[gi];
    end
  endgenerate

  // level each programmable pin drives when enabled
  always_comb begin
    fixed_level = '0;
    fixed_level[PIN_ACQ_TRIG_FIRST] = (nxt_state.acq_phase != ACQ_IDLE);
    fixed_level[PIN_ACQ_TRIG_SECOND] = (nxt_state.acq_phase == ACQ_POST) && acq_pretrigger_in;
    fixed_level[PIN_CONVERT] = !convert_event_in;
    fixed_level[PIN_COUNTER_B_SOURCE] = counter_b_source_in;
    fixed_level[PIN_COUNTER_B_GATE] = counter_b_gate_in;
    fixed_level[PIN_UPDATE] = !update_event_in;
    fixed_level[PIN_WAVEFORM_START] = nxt_state.wave_active;
    fixed_level[PIN_SCAN_START] = scan_start_in;
    fixed_level[PIN_COUNTER_A_SOURCE] = counter_a_source_in;
    fixed_level[PIN_COUNTER_A_GATE] = counter_a_gate_in;
  end

  // next-state logic for all outputs and phases
  always_comb begin
    nxt_state = state_ff;
    // acquisition phase: pretrigger holds pre until the post start or done
    case (state_ff.acq_phase)
      ACQ_IDLE: begin
        if (acq_start_in) begin
          nxt_state.acq_phase = acq_pretrigger_in ? ACQ_PRE : ACQ_POST;
        end
      end
      ACQ_PRE: begin
        if (acq_done_in) begin
          nxt_state.acq_phase = ACQ_IDLE;
        end else if (acq_post_start_in) begin
          nxt_state.acq_phase = ACQ_POST;
        end
      end
      ACQ_POST: begin
        if (acq_done_in) begin
          nxt_state.acq_phase = ACQ_IDLE;
        end
      end
      default: begin
        nxt_state.acq_phase = ACQ_IDLE;
      end
    endcase
    // waveform trigger stays high for the whole generation
    if (waveform_start_in) begin
      nxt_state.wave_active = 1'b1;
    end else if (waveform_done_in) begin
      nxt_state.wave_active = 1'b0;
    end
    if (strobe_toggle_in) begin
      nxt_state.strobe = !state_ff.strobe;
    end
    nxt_state.pin_oe = pin_oe_cfg_in;
    nxt_state.pin_drv = fixed_level;
    nxt_state.ctr_a_out = counter_a_output_in;
    nxt_state.ctr_b_out = counter_b_output_in;
    nxt_state.freq_generator_output = freq_generator_in;
    nxt_state.timing = routed;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff.pin_drv <= '0;
      state_ff.pin_oe <= PIN_OE_RESET;
      state_ff.strobe <= STROBE_RESET;
      state_ff.ctr_a_out <= 1'b0;
      state_ff.ctr_b_out <= 1'b0;
      state_ff.freq_generator_output <= 1'b0;
      state_ff.timing <= '0;
      state_ff.acq_phase <= ACQ_IDLE;
      state_ff.wave_active <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // every output straight from a flip-flop
  assign programmable_timing_pin_out = state_ff.pin_drv;
  assign programmable_timing_pin_oe_out = state_ff.pin_oe;
  assign software_strobe_out = state_ff.strobe;
  assign counter_a_output_out = state_ff.ctr_a_out;
  assign counter_b_output_out = state_ff.ctr_b_out;
  assign freq_generator_output_out = state_ff.freq_generator_output;
  assign timing_signal_out = state_ff.timing;

  // assertions
  sequence s_post_start;
    acq_start_in && !acq_pretrigger_in && state_ff.acq_phase == ACQ_IDLE;
  endsequence

  sequence s_pre_start;
    acq_start_in && acq_pretrigger_in && state_ff.acq_phase == ACQ_IDLE;
  endsequence

  // pretrigger run moving into its post phase, not cut by done
  sequence s_pre_to_post;
    state_ff.acq_phase == ACQ_PRE && acq_post_start_in && !acq_done_in && acq_pretrigger_in;
  endsequence

  a_strobe_toggles: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    strobe_toggle_in |=> software_strobe_out != $past(software_strobe_out))
    else $error("strobe did not toggle");

  a_strobe_holds: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !strobe_toggle_in |=> $stable(software_strobe_out))
    else $error("strobe moved without a toggle");

  a_pin_routing: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    source_sel_in[SEL_W-1:0] == PIN_CONVERT |=> timing_signal_out[0] == $past(pin_sync[PIN_CONVERT]))
    else $error("routed pin level mismatch");

  a_post_trigger_rise: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_post_start |=> programmable_timing_pin_out[PIN_ACQ_TRIG_FIRST])
    else $error("first trigger missed posttrigger start");

  a_trigger_drop: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    acq_done_in && state_ff.acq_phase != ACQ_IDLE |=> !programmable_timing_pin_out[PIN_ACQ_TRIG_FIRST])
    else $error("first trigger stayed high after done");

  a_pre_trigger_rise: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_pre_start |=> programmable_timing_pin_out[PIN_ACQ_TRIG_FIRST]
      && !programmable_timing_pin_out[PIN_ACQ_TRIG_SECOND])
    else $error("first trigger missed pretrigger start");

  a_second_trigger: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    programmable_timing_pin_out[PIN_ACQ_TRIG_SECOND] |-> state_ff.acq_phase == ACQ_POST)
    else $error("second trigger outside post phase");

  a_second_rise: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_pre_to_post |=> programmable_timing_pin_out[PIN_ACQ_TRIG_SECOND])
    else $error("second trigger missed post start");

  a_second_quiet: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !acq_pretrigger_in |=> !programmable_timing_pin_out[PIN_ACQ_TRIG_SECOND])
    else $error("second trigger used in posttrigger run");

  a_convert_fall: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    convert_event_in |=> !programmable_timing_pin_out[PIN_CONVERT])
    else $error("convert pin not low");

  a_convert_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !convert_event_in |=> programmable_timing_pin_out[PIN_CONVERT])
    else $error("convert pin not back high");

  a_ctr_b_source: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 programmable_timing_pin_out[PIN_COUNTER_B_SOURCE] == $past(counter_b_source_in))
    else $error("counter b source pin mismatch");

  a_ctr_b_gate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 programmable_timing_pin_out[PIN_COUNTER_B_GATE] == $past(counter_b_gate_in))
    else $error("counter b gate pin mismatch");

  a_counter_b_out: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 counter_b_output_out == $past(counter_b_output_in))
    else $error("counter b output mismatch");

  a_update_fall: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    update_event_in |=> !programmable_timing_pin_out[PIN_UPDATE])
    else $error("update pin not low");

  a_update_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !update_event_in |=> programmable_timing_pin_out[PIN_UPDATE])
    else $error("update pin not back high");

  a_wave_rise: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    waveform_start_in |=> programmable_timing_pin_out[PIN_WAVEFORM_START])
    else $error("waveform trigger not high");

  a_wave_fall: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    waveform_done_in && !waveform_start_in |=> !programmable_timing_pin_out[PIN_WAVEFORM_START])
    else $error("waveform trigger not low after done");

  a_scan_pulse: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    scan_start_in ##1 !scan_start_in |=> !programmable_timing_pin_out[PIN_SCAN_START])
    else $error("scan pulse too long");

  a_scan_follows: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 programmable_timing_pin_out[PIN_SCAN_START] == $past(scan_start_in))
    else $error("scan pulse missing");

  a_ctr_a_source: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 programmable_timing_pin_out[PIN_COUNTER_A_SOURCE] == $past(counter_a_source_in))
    else $error("counter a source pin mismatch");

  a_ctr_a_gate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 programmable_timing_pin_out[PIN_COUNTER_A_GATE] == $past(counter_a_gate_in))
    else $error("counter a gate pin mismatch");

  a_counter_a_out: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 counter_a_output_out == $past(counter_a_output_in))
    else $error("counter a output mismatch");

  a_freq_generator_output: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 freq_generator_output_out == $past(freq_generator_in))
    else $error("frequency output mismatch");

  a_shared_pin: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    source_sel_in[SEL_W-1:0] == source_sel_in[2*SEL_W-1:SEL_W] && source_sel_in[SEL_W-1:0] < SEL_W'(NPINS)
      |=> timing_signal_out[0] == timing_signal_out[1])
    else $error("signals sharing a pin disagree");

  a_oe_follows: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ##1 programmable_timing_pin_oe_out == $past(pin_oe_cfg_in))
    else $error("driver enable mismatch");

  a_internal_src: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    source_sel_in[SEL_W-1:0] == SEL_INTERNAL |=> timing_signal_out[0] == $past(internal_source_in[0]))
    else $error("internal source not routed");

  a_reset_oe: assert property (@(posedge clk_sys_in)
    !rstn_in |-> programmable_timing_pin_oe_out == PIN_OE_RESET)
    else $error("pin driver enabled during reset");

endmodule : timing_signal_terminal_pins
`default_nettype wire

// ===== test/ext_timing_circuit.sv
// Purpose: external circuit wired to the timing screw terminals
// Assumes: every terminal carries a pull-up to the supply
// Notes: a fight between device and circuit shows as unknown
`timescale 1ns/10ps
`default_nettype none
module ext_timing_circuit
  import timing_pins_pkg::*;
(
  input wire logic [NUM_PINS-1:0] dev_level_in,
  input wire logic [NUM_PINS-1:0] dev_oe_in,
  input wire logic [NUM_PINS-1:0] drive_en_in,
  input wire logic [NUM_PINS-1:0] drive_level_in,
  output logic [NUM_PINS-1:0] wire_level_out
);
  // resolve each terminal; released lines float up to the pull-up level
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (dev_oe_in[i] && drive_en_in[i])
        wire_level_out[i] = 1'bx;
      else if (dev_oe_in[i])
        wire_level_out[i] = dev_level_in[i];
      else if (drive_en_in[i])
        wire_level_out[i] = drive_level_in[i];
      else
        wire_level_out[i] = 1'b1;
    end
  end
endmodule : ext_timing_circuit
`default_nettype wire

// ===== test/timing_signal_terminal_pins_tb.sv
// Purpose: self-checking bench for the timing terminal pins
// Assumes: pin levels are judged on the resolved terminal wire
// Notes: inputs move on rising edges, checks sit on falling edges
`timescale 1ns/10ps
`default_nettype none
module timing_signal_terminal_pins_tb
  import timing_pins_pkg::*;
;
  logic clk, rstn_in, strobe_toggle_in, acq_start_in, acq_pretrigger_in, acq_post_start_in, acq_done_in;
  logic convert_event_in, update_event_in, waveform_start_in, waveform_done_in, scan_start_in;
  logic counter_a_source_in, counter_a_gate_in, counter_a_output_in, counter_b_source_in, counter_b_gate_in;
  logic counter_b_output_in, freq_generator_in, software_strobe_out, counter_a_output_out;
  logic counter_b_output_out, freq_generator_output_out;
  logic [NUM_PINS-1:0] pin_oe_cfg_in, programmable_timing_pin_out, programmable_timing_pin_oe_out;
  logic [NUM_PINS-1:0] pl, ext_en, ext_lvl;
  logic [NUM_TIMING_SIGNALS*SEL_W-1:0] source_sel_in;
  logic [NUM_TIMING_SIGNALS-1:0] internal_source_in, timing_signal_out;
  int error_cnt, num_checks;

  timing_signal_terminal_pins dut (.clk_sys_in(clk), .rstn_in, .strobe_toggle_in, .pin_oe_cfg_in, .source_sel_in,
    .internal_source_in, .acq_start_in, .acq_pretrigger_in, .acq_post_start_in, .acq_done_in, .convert_event_in,
    .update_event_in, .waveform_start_in, .waveform_done_in, .scan_start_in, .counter_a_source_in,
    .counter_a_gate_in, .counter_a_output_in, .counter_b_source_in, .counter_b_gate_in, .counter_b_output_in,
    .freq_generator_in, .programmable_timing_pin_in(pl), .programmable_timing_pin_out,
    .programmable_timing_pin_oe_out, .software_strobe_out, .counter_a_output_out, .counter_b_output_out,
    .freq_generator_output_out, .timing_signal_out);

  // far side: terminal wires shared by device and external circuit
  ext_timing_circuit ext (.dev_level_in(programmable_timing_pin_out), .dev_oe_in(programmable_timing_pin_oe_out),
    .drive_en_in(ext_en), .drive_level_in(ext_lvl), .wire_level_out(pl));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one answering edge, then settle half a cycle
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic t_strobe();
    logic e;
    e = STROBE_RESET;
    repeat (2) begin
      @(posedge clk) strobe_toggle_in <= 1'b1;
      @(posedge clk) strobe_toggle_in <= 1'b0;
      e = ~e;
      @(negedge clk) chk("strobe", software_strobe_out, e);
    end
    $display("test strobe done");
  endtask : t_strobe

  task automatic t_oe();
    for (int i = 0; i < NUM_PINS; i++) begin
      @(posedge clk) pin_oe_cfg_in <= 10'h001 << i;
      step();
      chk("oe_one", programmable_timing_pin_oe_out, 10'h001 << i);
    end
    @(posedge clk) pin_oe_cfg_in <= 10'h3FF;
    step();
    $display("test oe done");
  endtask : t_oe

  // pre low: posttrigger run, second trigger must stay low
  task automatic t_acq(input logic pre);
    @(negedge clk) chk("trig_idle", pl[1:0], 2'h0);
    @(posedge clk) acq_pretrigger_in <= pre;
    acq_start_in <= 1'b1;
    @(posedge clk) acq_start_in <= 1'b0;
    @(negedge clk) chk("acq_trigger_first", pl[0], 1'b1);
    chk("acq_trigger_second_early", pl[1], 1'b0);
    @(posedge clk) acq_post_start_in <= 1'b1;
    @(posedge clk) acq_post_start_in <= 1'b0;
    @(negedge clk) chk("acq_trigger_second", pl[1], pre);
    @(posedge clk) acq_done_in <= 1'b1;
    @(posedge clk) acq_done_in <= 1'b0;
    @(negedge clk) chk("trig_end", pl[1:0], 2'h0);
    $display("test acq pre=%0d done", pre);
  endtask : t_acq

  task automatic t_events();
    @(negedge clk) chk("ev_idle", {pl[7:5], pl[2]}, 4'h3);
    @(posedge clk) convert_event_in <= 1'b1;
    update_event_in <= 1'b1;
    @(posedge clk) convert_event_in <= 1'b0;
    update_event_in <= 1'b0;
    waveform_start_in <= 1'b1;
    @(negedge clk) chk("conv_low", pl[2], 1'b0);
    chk("upd_low", pl[5], 1'b0);
    @(posedge clk) waveform_start_in <= 1'b0;
    scan_start_in <= 1'b1;
    @(negedge clk) chk("conv_back", {pl[5], pl[2]}, 2'h3);
    chk("wave_up", pl[6], 1'b1);
    @(posedge clk) scan_start_in <= 1'b0;
    waveform_done_in <= 1'b1;
    @(negedge clk) chk("scan_up", pl[7], 1'b1);
    @(posedge clk) waveform_done_in <= 1'b0;
    @(negedge clk) chk("scan_once", pl[7], 1'b0);
    chk("wave_end", pl[6], 1'b0);
    $display("test events done");
  endtask : t_events

  // walking one across the counter and generator levels catches swaps
  task automatic t_counters();
    logic [6:0] v;
    for (int i = 0; i < 8; i++) begin
      v = (i < 7) ? 7'h01 << i : 7'h00;
      @(posedge clk) {counter_a_source_in, counter_a_gate_in, counter_a_output_in, counter_b_source_in} <= v[6:3];
      {counter_b_gate_in, counter_b_output_in, freq_generator_in} <= v[2:0];
      step();
      chk("a_src", pl[8], v[6]);
      chk("a_gate", pl[9], v[5]);
      chk("a_out", counter_a_output_out, v[4]);
      chk("b_src", pl[3], v[3]);
      chk("b_gate", pl[4], v[2]);
      chk("b_out", counter_b_output_out, v[1]);
      chk("freq", freq_generator_output_out, v[0]);
    end
    $display("test counters done");
  endtask : t_counters

  // signal i listens to pin (base + mul*i) mod pins; mul 0 shares one pin
  task automatic t_route(input logic [9:0] lv, input int base, input int mul);
    logic [12:0] e;
    @(posedge clk) ext_lvl <= lv;
    for (int i = 0; i < NUM_TIMING_SIGNALS; i++) begin
      source_sel_in[i*SEL_W +: SEL_W] <= SEL_W'((base + mul * i) % NUM_PINS);
      e[i] = lv[(base + mul * i) % NUM_PINS];
    end
    repeat (3) @(posedge clk);
    @(negedge clk) chk("pin_in", pl, lv);
    chk("route", timing_signal_out, e);
    $display("test route base=%0d done", base);
  endtask : t_route

  task automatic t_internal();
    @(posedge clk) source_sel_in <= {NUM_TIMING_SIGNALS{SEL_INTERNAL}};
    internal_source_in <= 13'h1A5C;
    step();
    chk("internal", timing_signal_out, 13'h1A5C);
    $display("test internal done");
  endtask : t_internal

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #50000;
    error_cnt++;
    end_sim();
  end

  initial begin
    {strobe_toggle_in, acq_start_in, acq_pretrigger_in, acq_post_start_in, acq_done_in} = 5'h00;
    {convert_event_in, update_event_in, waveform_start_in, waveform_done_in, scan_start_in} = 5'h00;
    {counter_a_source_in, counter_a_gate_in, counter_a_output_in, counter_b_source_in} = 4'h0;
    {counter_b_gate_in, counter_b_output_in, freq_generator_in} = 3'h0;
    {pin_oe_cfg_in, ext_en, ext_lvl} = 30'h0;
    source_sel_in = '1;
    internal_source_in = 13'h0000;
    error_cnt = 0;
    num_checks = 0;
    rstn_in = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk) chk("rst_oe", programmable_timing_pin_oe_out, 10'h000);
    chk("rst_strobe", software_strobe_out, STROBE_RESET);
    @(posedge clk) rstn_in <= 1'b1;
    step();
    chk("rel_pins", pl, 10'h3FF);
    t_strobe();
    t_oe();
    t_acq(1'b0);
    t_acq(1'b1);
    t_events();
    t_counters();
    @(posedge clk) pin_oe_cfg_in <= 10'h000;
    step();
    @(posedge clk) ext_en <= 10'h3FF;
    t_route(10'h2A5, 0, 1);
    t_route(10'h15A, 3, 0);
    t_internal();
    end_sim();
  end
endmodule : timing_signal_terminal_pins_tb
`default_nettype wire
